// File: core/flash_guard_cfg.svh
// Constants for the flash page lock guard
`ifndef FLASH_GUARD_CFG_SVH
`define FLASH_GUARD_CFG_SVH
`define LOCK_ERASED_VALUE 8'hff
`define ADDR_WIDTH        16
`define PAGE_SHIFT        9
`define LOCK_PAGE_INDEX   3'h3
`define RESERVED_BASE     16'h07fe
`define LOCK_BYTE_ADDR    16'h07ff
`endif

// File: core/flash_guard_pkg.sv
// Types for the flash page lock guard
package flash_guard_pkg;
	typedef enum logic [1:0] {
		op_read,
		op_write,
		op_erase,
		op_device_erase
	} op_kind_t;
	typedef enum logic [1:0] {
		src_debug,
		src_fw_unlocked,
		src_fw_locked
	} source_t;
	typedef enum logic [1:0] {
		verdict_permit,
		verdict_ignore,
		verdict_fault
	} verdict_t;
endpackage : flash_guard_pkg

// File: core/lock_state_if.sv
// Lock state carried from the holder to the checker
`timescale 1ns/1ps
interface lock_state_if;
	logic [7:0] lock_map;
	logic       any_locked;
	modport holder (output lock_map, output any_locked);
	modport checker_side (input lock_map, input any_locked);
endinterface : lock_state_if

// File: core/lock_state_holder.sv
// Lock byte holder: stored value and the copy applied since reset
`timescale 1ns/1ps
`include "flash_guard_cfg.svh"
module lock_state_holder (
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire logic     store_we,
	input  wire logic [7:0] store_data,
	input  wire logic     device_erase,
	output logic [7:0]    stored,
	lock_state_if.holder  lk
);
	// Power-up value only: the stored lock byte is non-volatile and ignores rst
	logic [7:0] lock_store = `LOCK_ERASED_VALUE;
	logic [7:0] active;
	logic [7:0] next_stored;
	logic [7:0] next_active;
	logic       loaded;
	logic       next_loaded;

	always_comb begin
		next_stored = stored;
		next_active = active;
		next_loaded = 1'b1;
		if (device_erase) begin
			next_stored = `LOCK_ERASED_VALUE;
		end else if (store_we) begin
			next_stored = store_data;
		end
		// New lock state takes effect only at reload after reset
		if (!loaded) begin
			next_active = stored;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			loaded <= 1'b0;
		end else begin
			lock_store <= next_stored;
			active <= next_active;
			loaded <= next_loaded;
		end
	end

	assign stored = lock_store;

	assign lk.lock_map   = loaded ? active : `LOCK_ERASED_VALUE;
	assign lk.any_locked = loaded ? (active != `LOCK_ERASED_VALUE) : 1'b0;
endmodule : lock_state_holder

// File: core/flash_page_lock_guard.sv
// Flash page lock guard: checks each flash request against lock state
`timescale 1ns/1ps
`include "flash_guard_cfg.svh"
// What this block does
// - Unlocked pages open to every source
// - Locked pages: debug refused, unlocked firmware faults
// - Lock page access free until something locked
// - Lock byte read follows same policy
// - Unlocked: only debug may erase lock page
// - Locked: lock page cleared only by device erase
// - Locking more pages refused or faults
// - Unlocking single pages refused or faults
// - Reserved area refused or faults
// - Device erase clears every page, lock included
// - Firmware violation resets, sets fault flag
// - Debug violations silently dropped, never reset
// - Any lock also locks lock page
// - Written lock byte fixed until device erase
// - New lock state applies after next reset
module flash_page_lock_guard #(
	parameter int ADDR_W = `ADDR_WIDTH
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     req_valid,
	input  wire flash_guard_pkg::op_kind_t req_op,
	input  wire logic                     req_from_debug,
	input  wire logic [ADDR_W-1:0]        req_addr,
	input  wire logic [7:0]               req_wdata,
	input  wire logic [ADDR_W-1:0]        exec_addr,
	output logic                          grant,
	output logic                          discard,
	output logic                          fault_reset_req,
	output logic                          flash_fault_reset_flag,
	output logic                          erase_all,
	output logic [7:0]                    lock_value
);
	lock_state_if lk ();

	// ----------------------------------------------------------------
	// Verdict logic
	// ----------------------------------------------------------------
	function automatic logic page_locked(input logic [7:0] map, input logic [ADDR_W-1:0] a);
		logic [2:0] pg;
		pg = a[`PAGE_SHIFT+2:`PAGE_SHIFT];
		return !map[pg];
	endfunction : page_locked

	flash_guard_pkg::source_t  src;
	flash_guard_pkg::verdict_t verdict;
	logic                      on_lock_page;
	logic                      in_reserved;
	logic                      tgt_locked;
	logic                      lock_write;
	logic                      do_store;
	logic                      next_grant;
	logic                      next_discard;
	logic                      next_fault;
	logic                      next_flag;
	logic                      next_erase_all;
	logic                      fault_flag = 1'b0;

	always_comb begin
		// Source sampled with the request from the executing page
		if (req_from_debug) begin
			src = flash_guard_pkg::src_debug;
		end else if (page_locked(lk.lock_map, exec_addr) ||
			(lk.any_locked && exec_addr[`PAGE_SHIFT+2:`PAGE_SHIFT] == `LOCK_PAGE_INDEX)) begin
			src = flash_guard_pkg::src_fw_locked;
		end else begin
			src = flash_guard_pkg::src_fw_unlocked;
		end
		on_lock_page = req_addr[`PAGE_SHIFT+2:`PAGE_SHIFT] == `LOCK_PAGE_INDEX;
		in_reserved  = req_addr >= `RESERVED_BASE && req_addr != `LOCK_BYTE_ADDR;
		tgt_locked   = page_locked(lk.lock_map, req_addr);
		lock_write   = req_op == flash_guard_pkg::op_write && req_addr == `LOCK_BYTE_ADDR;
		verdict      = flash_guard_pkg::verdict_permit;
		if (req_op == flash_guard_pkg::op_device_erase) begin
			verdict = (src == flash_guard_pkg::src_debug) ? flash_guard_pkg::verdict_permit
				: flash_guard_pkg::verdict_fault;
		end else if (in_reserved) begin
			verdict = flash_guard_pkg::verdict_fault;
		end else if (lock_write && lock_value != `LOCK_ERASED_VALUE) begin
			verdict = flash_guard_pkg::verdict_fault;
		end else if (on_lock_page && req_op == flash_guard_pkg::op_erase) begin
			verdict = (src == flash_guard_pkg::src_debug && !lk.any_locked)
				? flash_guard_pkg::verdict_permit : flash_guard_pkg::verdict_fault;
		end else if (on_lock_page) begin
			verdict = (!lk.any_locked || src == flash_guard_pkg::src_fw_locked)
				? flash_guard_pkg::verdict_permit : flash_guard_pkg::verdict_fault;
		end else if (tgt_locked) begin
			verdict = (src == flash_guard_pkg::src_fw_locked)
				? flash_guard_pkg::verdict_permit : flash_guard_pkg::verdict_fault;
		end else begin
			verdict = flash_guard_pkg::verdict_permit;
		end
		// Debug violations become a silent discard
		if (verdict == flash_guard_pkg::verdict_fault && src == flash_guard_pkg::src_debug) begin
			verdict = flash_guard_pkg::verdict_ignore;
		end
		do_store       = req_valid && lock_write && verdict == flash_guard_pkg::verdict_permit;
		next_grant     = req_valid && verdict == flash_guard_pkg::verdict_permit;
		next_discard   = req_valid && verdict == flash_guard_pkg::verdict_ignore;
		next_fault     = req_valid && verdict == flash_guard_pkg::verdict_fault;
		next_erase_all = next_grant && req_op == flash_guard_pkg::op_device_erase;
		next_flag      = flash_fault_reset_flag;
		if (next_fault) begin
			next_flag = 1'b1;
		end else if (req_valid) begin
			next_flag = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Fault flag survives rst: it must read one after the fault reset
	always_ff @(posedge clk) begin
		fault_flag <= next_flag;
		if (rst) begin
			grant           <= 1'b0;
			discard         <= 1'b0;
			fault_reset_req <= 1'b0;
			erase_all       <= 1'b0;
		end else begin
			grant           <= next_grant;
			discard         <= next_discard;
			fault_reset_req <= next_fault;
			erase_all       <= next_erase_all;
		end
	end

	assign flash_fault_reset_flag = fault_flag;

	lock_state_holder u_holder (
		.clk          (clk),
		.rst          (rst),
		.store_we     (do_store),
		.store_data   (req_wdata),
		.device_erase (next_erase_all),
		.stored       (lock_value),
		.lk           (lk.holder)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_debug_never_resets;
		@(posedge clk) disable iff (rst) req_valid && req_from_debug |=> !fault_reset_req;
	endproperty
	a_debug_never_resets: assert property (p_debug_never_resets) else $error("debug reset");

	property p_fault_sets_flag;
		@(posedge clk) disable iff (rst) fault_reset_req |-> flash_fault_reset_flag;
	endproperty
	a_fault_sets_flag: assert property (p_fault_sets_flag) else $error("flag not set");

	property p_unlocked_granted;
		@(posedge clk) disable iff (rst) req_valid && !on_lock_page && !in_reserved
			&& !tgt_locked && req_op == flash_guard_pkg::op_read |=> grant;
	endproperty
	a_unlocked_granted: assert property (p_unlocked_granted) else $error("unlocked denied");

	property p_locked_fw_fault;
		@(posedge clk) disable iff (rst) req_valid && !on_lock_page && !in_reserved && tgt_locked
			&& src == flash_guard_pkg::src_fw_unlocked && req_op != flash_guard_pkg::op_device_erase
			&& !lock_write |=> fault_reset_req;
	endproperty
	a_locked_fw_fault: assert property (p_locked_fw_fault) else $error("no fault");

	property p_reserved_blocked;
		@(posedge clk) disable iff (rst) req_valid && in_reserved
			&& req_op != flash_guard_pkg::op_device_erase |=> !grant;
	endproperty
	a_reserved_blocked: assert property (p_reserved_blocked) else $error("reserved granted");

	property p_fw_lock_erase_fault;
		@(posedge clk) disable iff (rst) req_valid && !req_from_debug && on_lock_page
			&& !in_reserved && req_op == flash_guard_pkg::op_erase |=> fault_reset_req;
	endproperty
	a_fw_lock_erase_fault: assert property (p_fw_lock_erase_fault) else $error("erase ok");

	property p_lock_fixed;
		@(posedge clk) disable iff (rst) $past(lock_value) != 8'hff && !$past(erase_all)
			&& !$past(next_erase_all) |-> $stable(lock_value);
	endproperty
	a_lock_fixed: assert property (p_lock_fixed) else $error("lock byte changed");

	property p_device_erase_clears;
		@(posedge clk) disable iff (rst) next_erase_all |=> lock_value == 8'hff;
	endproperty
	a_device_erase_clears: assert property (p_device_erase_clears) else $error("not erased");

	property p_one_verdict;
		@(posedge clk) disable iff (rst) !(grant && fault_reset_req) && !(grant && discard);
	endproperty
	a_one_verdict: assert property (p_one_verdict) else $error("two verdicts");

	c_fault: cover property (@(posedge clk) disable iff (rst) fault_reset_req);
	c_discard: cover property (@(posedge clk) disable iff (rst) discard);
	c_erase_all: cover property (@(posedge clk) disable iff (rst) erase_all);
endmodule : flash_page_lock_guard

// File: verification/flash_requester.sv
// Requester model: firmware and debug port issuing flash requests
`timescale 1ns/1ps
module flash_requester (
	input  wire logic                 clk,
	input  wire logic                 grant,
	input  wire logic                 discard,
	input  wire logic                 fault_reset_req,
	input  wire logic                 erase_all,
	output flash_guard_pkg::op_kind_t req_op,
	output logic                      req_valid,
	output logic                      req_from_debug,
	output logic [15:0]               req_addr,
	output logic [7:0]                req_wdata,
	output logic [15:0]               exec_addr
);
	// ----------
	// Request
	// ----------
	initial begin
		req_valid = 1'b0;
		req_op = flash_guard_pkg::op_read;
		req_from_debug = 1'b0;
		req_addr = 16'h0000;
		req_wdata = 8'h00;
		exec_addr = 16'h0000;
	end
	task automatic issue(input flash_guard_pkg::op_kind_t op, input logic dbg,
		input logic [15:0] a, input logic [7:0] d, input logic [15:0] x, output logic [3:0] v);
		int n;
		@(posedge clk);
		req_valid <= 1'b1;
		req_op <= op;
		req_from_debug <= dbg;
		req_addr <= a;
		req_wdata <= d;
		exec_addr <= x;
		@(posedge clk);
		// Address, write data and exec address flip so a stale value cannot pass as a match
		req_valid <= 1'b0;
		req_addr <= ~a;
		req_wdata <= ~d;
		exec_addr <= ~x;
		v = 4'h0;
		for (n = 0; n < 3 && v == 4'h0; n++) begin
			#1 v = {erase_all, grant, discard, fault_reset_req};
			if (v == 4'h0) @(posedge clk);
		end
	endtask : issue
endmodule : flash_requester

// File: verification/test_flash_page_lock_guard.sv
// Self-checking bench for the flash page lock guard
`timescale 1ns/1ps
module test_flash_page_lock_guard;
	// ----------
	// Signals
	// ----------
	logic                      clk, rst, req_valid, req_from_debug;
	logic                      grant, discard, fault_reset_req, flash_fault_reset_flag, erase_all;
	flash_guard_pkg::op_kind_t req_op;
	logic [15:0]               req_addr, exec_addr;
	logic [7:0]                req_wdata, lock_value;
	logic [3:0]                v;
	int                        err_count, checked;
	localparam flash_guard_pkg::op_kind_t rd = flash_guard_pkg::op_read;
	localparam flash_guard_pkg::op_kind_t wr = flash_guard_pkg::op_write;
	localparam flash_guard_pkg::op_kind_t er = flash_guard_pkg::op_erase;
	localparam logic [2:0] g = 3'b100, d = 3'b010, f = 3'b001;
	// Firmware running from unlocked page 1 and from page 0
	localparam logic [15:0] xu = 16'h0200, xl = 16'h0000;
	flash_page_lock_guard dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
		.req_from_debug(req_from_debug), .req_addr(req_addr), .req_wdata(req_wdata),
		.exec_addr(exec_addr), .grant(grant), .discard(discard),
		.fault_reset_req(fault_reset_req), .flash_fault_reset_flag(flash_fault_reset_flag),
		.erase_all(erase_all), .lock_value(lock_value));
	flash_requester req (.clk(clk), .grant(grant), .discard(discard),
		.fault_reset_req(fault_reset_req), .erase_all(erase_all), .req_op(req_op),
		.req_valid(req_valid), .req_from_debug(req_from_debug), .req_addr(req_addr),
		.req_wdata(req_wdata), .exec_addr(exec_addr));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ----------
	// Helpers
	// ----------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t saw %h wanted %h", $time, seen, exp);
		end
	endtask : check
	task automatic go(input flash_guard_pkg::op_kind_t op, input logic dbg,
		input logic [15:0] a, input logic [7:0] wd, input logic [15:0] x, input logic [2:0] e);
		req.issue(op, dbg, a, wd, x, v);
		if (v == 4'h0) begin
			err_count++;
			$display("[ERR] %0t no answer", $time);
			complete_run();
		end
		check({5'h0, v[2:0]}, {5'h0, e});
	endtask : go
	task automatic do_reset(input int n);
		@(posedge clk);
		rst <= 1'b1;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : do_reset
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run
	// ----------
	// Scenarios
	// ----------
	task automatic t_open;
		check(lock_value, 8'hff);
		go(rd, 1'b1, 16'h0000, 8'h00, xl, g);
		go(wr, 1'b0, 16'h0000, 8'h5a, xu, g);
		go(rd, 1'b0, 16'h0600, 8'h00, xu, g);
		go(rd, 1'b1, 16'h07ff, 8'h00, xl, g);
		go(er, 1'b0, 16'h0600, 8'h00, xu, f);
		check({7'h0, flash_fault_reset_flag}, 8'h01);
		go(er, 1'b1, 16'h0600, 8'h00, xl, g);
		check({7'h0, flash_fault_reset_flag}, 8'h00);
		go(rd, 1'b1, 16'h07fe, 8'h00, xl, d);
		go(wr, 1'b0, 16'h07fe, 8'h00, xu, f);
		do_reset(2);
		check({7'h0, flash_fault_reset_flag}, 8'h01);
		$display("t_open done");
	endtask : t_open
	task automatic t_lock;
		go(wr, 1'b0, 16'h07ff, 8'hfe, xu, g);
		check(lock_value, 8'hfe);
		go(rd, 1'b0, 16'h0000, 8'h00, xu, g);
		do_reset(2);
		go(rd, 1'b0, 16'h0000, 8'h00, xu, f);
		go(rd, 1'b1, 16'h0000, 8'h00, xl, d);
		go(rd, 1'b0, 16'h0000, 8'h00, xl, g);
		go(rd, 1'b0, 16'h0600, 8'h00, xu, f);
		go(rd, 1'b0, 16'h0600, 8'h00, xl, g);
		go(rd, 1'b1, 16'h07ff, 8'h00, xl, d);
		go(rd, 1'b0, 16'h07ff, 8'h00, xl, g);
		go(wr, 1'b0, 16'h07ff, 8'hfc, xl, f);
		go(wr, 1'b1, 16'h07ff, 8'hff, xl, d);
		go(er, 1'b0, 16'h0600, 8'h00, xl, f);
		go(er, 1'b1, 16'h0600, 8'h00, xl, d);
		go(flash_guard_pkg::op_device_erase, 1'b0, 16'h0000, 8'h00, xl, f);
		check(lock_value, 8'hfe);
		$display("t_lock done");
	endtask : t_lock
	task automatic t_wipe;
		go(flash_guard_pkg::op_device_erase, 1'b1, 16'h0000, 8'h00, xl, g);
		check({7'h0, v[3]}, 8'h01);
		check(lock_value, 8'hff);
		do_reset(2);
		go(rd, 1'b0, 16'h0000, 8'h00, xu, g);
		$display("t_wipe done");
	endtask : t_wipe
	initial begin
		rst = 1'b1;
		err_count = 0;
		checked = 0;
		do_reset(5);
		t_open();
		t_lock();
		t_wipe();
		complete_run();
	end
endmodule : test_flash_page_lock_guard
